// ### pkg/pcs_pkg.sv
package pcs_pkg;
  // Clock, timing and step limit.
  localparam int CLK_PERIOD_NS = 10;
  localparam int PARAM_TIME_NS = 100000;
  localparam int PARAM_CYCLES = (PARAM_TIME_NS + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam int GAIN_TIME_NS = 300000;
  localparam logic [16:0] GAIN_TICKS = 17'(GAIN_TIME_NS / PARAM_TIME_NS);
  localparam int INIT_TIME_NS = 100000;
  localparam int INIT_CYCLES = INIT_TIME_NS / CLK_PERIOD_NS;
  localparam logic [16:0] DWELL_MIN = 17'h00001;
  localparam logic [16:0] DWELL_MAX = 17'h186a0;
  localparam logic [28:0] STEP_LIMIT_MUL = 29'h0000064;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PASSWORD = 8'h08;
  localparam logic [7:0] REG_AUTO_EXEC = 8'h0c;
  localparam logic [7:0] REG_DIVISIONS = 8'h10;
  localparam logic [7:0] REG_PROG_ADDR = 8'h14;
  localparam logic [7:0] REG_PROG_DATA = 8'h18;
  localparam logic [7:0] REG_CHAN_ENTRY = 8'h1c;
  localparam logic [7:0] REG_GLOBAL_BASE = 8'h20;
  localparam logic [7:0] REG_EFFECT_BASE = 8'h30;

  // Control register fields.
  localparam int CTRL_KEEP_BIT = 0;
  localparam int CTRL_HOLD_NC_BIT = 1;
  localparam int CTRL_ESTOP_NC_BIT = 2;

  // Reset values and limits.
  localparam logic [8:0] AUTO_EXEC_RST = 9'h1ff;
  localparam logic [21:0] DIVISIONS_RST = 22'h057e40;
  localparam logic [21:0] DIVISIONS_MAX = 22'h280000;
  // Arbitrary unlock key.
  localparam logic [31:0] PASSWORD_KEY = 32'h5a5a0001;

  // Program word: opcode in [31:28], operand in [27:0].
  localparam logic [3:0] OP_END = 4'h0;
  localparam logic [3:0] OP_SET = 4'h1;
  localparam logic [3:0] OP_GAIN = 4'h2;
  localparam logic [3:0] OP_DWELL = 4'h3;
  localparam logic [3:0] OP_STEP = 4'h4;
  localparam logic [3:0] OP_JUMP = 4'h5;
  localparam logic [3:0] OP_RESTORE = 4'h6;

  localparam int NPARAM = 4;
  localparam int PROG_DEPTH = 64;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RUN = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_MOVE = 5'b01000,
    ST_DONE = 5'b10000
  } pcs_state_t;
endpackage

// ### rtl/pcs_sequencer.sv
`timescale 1ns/100ps
module pcs_sequencer #(
  parameter int PARAM_CYCLES = pcs_pkg::PARAM_CYCLES,
  parameter int INIT_CYCLES = pcs_pkg::INIT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_program_start,
  input wire logic [7:0] i_channel_select_inputs,
  input wire logic i_operation_hold_input,
  input wire logic i_emergency_stop_input,
  input wire logic i_alarm,
  input wire logic i_warning,
  input wire logic i_motion_active,
  input wire logic i_positioning_done,
  input wire logic i_target_held,
  output logic o_busy,
  output logic o_normal_state_output,
  output logic o_in_position_output,
  output logic o_estop_active,
  output logic [31:0] o_move_steps,
  output logic o_move_strobe
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    pcs_pkg::pcs_state_t state;
    logic start_prev;
    logic busy;
    logic [5:0] pc;
    logic [7:0] chan;
    logic keep;
    logic hold_nc;
    logic estop_nc;
    logic unlocked;
    logic [8:0] auto_exec;
    logic [21:0] divisions;
    logic [5:0] prog_addr;
    logic [3:0] local_valid;
    logic [3:0][23:0] local_p;
    logic [3:0][23:0] global_p;
    logic [16:0] wait_ticks;
    logic [15:0] tick_cnt;
    logic [19:0] init_cnt;
    logic init_done;
    logic cmd_error;
    logic [31:0] move_steps;
    logic move_strobe;
    logic [31:0] rdata;
  } pcs_regs_t;
  pcs_regs_t s_r;
  pcs_regs_t s_nxt;
  // Program store and channel entry table live outside the struct.
  logic [31:0] prog_mem [pcs_pkg::PROG_DEPTH];
  logic [5:0] chan_entry [256];

  logic [31:0] word;
  logic [3:0] opcode;
  logic hold_act;
  logic estop_act;
  logic tick;
  logic start_edge;
  logic [28:0] step_lim;
  logic [27:0] step_abs;
  logic [3:0][23:0] eff_p;
  logic [16:0] dwell_val;
  ////////////////////////////////////////////////////////////////////////////
  assign word = prog_mem[s_r.pc];
  assign opcode = word[31:28];
  assign hold_act = s_r.hold_nc ? ~i_operation_hold_input :
    i_operation_hold_input;
  assign estop_act = s_r.estop_nc ? ~i_emergency_stop_input :
    i_emergency_stop_input;
  assign tick = (s_r.tick_cnt == 16'(PARAM_CYCLES - 1));
  assign start_edge = i_program_start & ~s_r.start_prev;
  assign step_lim = 29'(s_r.divisions) * pcs_pkg::STEP_LIMIT_MUL;
  assign step_abs = word[27] ? 28'(-word[27:0]) : word[27:0];
  assign dwell_val = word[16:0];

  genvar gi;
  generate
    for (gi = 0; gi < pcs_pkg::NPARAM; gi++)
    begin : g_eff
      assign eff_p[gi] = s_r.local_valid[gi] ? s_r.local_p[gi] :
        s_r.global_p[gi];
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.start_prev = i_program_start;
    s_nxt.move_strobe = 1'b0;
    s_nxt.rdata = 32'h00000000;
    if (!s_r.init_done)
    begin
      s_nxt.init_cnt = s_r.init_cnt + 20'h00001;
      if (s_r.init_cnt == 20'(INIT_CYCLES - 1))
      begin
        s_nxt.init_done = 1'b1;
        if (!s_r.auto_exec[8] && !estop_act)
        begin
          s_nxt.chan = s_r.auto_exec[7:0];
          s_nxt.pc = chan_entry[s_r.auto_exec[7:0]];
          s_nxt.busy = 1'b1;
          s_nxt.state = pcs_pkg::ST_RUN;
        end
      end
    end
    case (s_r.state)
      pcs_pkg::ST_IDLE:
      begin
        if (start_edge && s_r.init_done && !estop_act)
        begin
          s_nxt.chan = i_channel_select_inputs;
          s_nxt.pc = chan_entry[i_channel_select_inputs];
          s_nxt.busy = 1'b1;
          s_nxt.state = pcs_pkg::ST_RUN;
        end
      end
      pcs_pkg::ST_RUN:
      begin
        if (!hold_act)
        begin
          s_nxt.pc = s_r.pc + 6'h01;
          s_nxt.tick_cnt = 16'h0000;
          case (opcode)
            pcs_pkg::OP_END: s_nxt.state = pcs_pkg::ST_DONE;
            pcs_pkg::OP_SET:
            begin
              s_nxt.local_p[word[25:24]] = word[23:0];
              s_nxt.local_valid[word[25:24]] = 1'b1;
              s_nxt.wait_ticks = 17'h00001;
              s_nxt.state = pcs_pkg::ST_WAIT;
            end
            pcs_pkg::OP_GAIN:
            begin
              // Gain 0 is combined, 1 position and 2 velocity.
              s_nxt.local_p[0] = word[23:0];
              s_nxt.local_p[1] = word[23:0];
              s_nxt.local_p[2] = word[23:0];
              s_nxt.local_valid[2:0] = 3'h7;
              s_nxt.wait_ticks = pcs_pkg::GAIN_TICKS;
              s_nxt.state = pcs_pkg::ST_WAIT;
            end
            pcs_pkg::OP_DWELL:
            begin
              if (dwell_val >= pcs_pkg::DWELL_MIN &&
                  dwell_val <= pcs_pkg::DWELL_MAX)
              begin
                s_nxt.wait_ticks = dwell_val;
                s_nxt.state = pcs_pkg::ST_WAIT;
              end
              else
              begin
                s_nxt.cmd_error = 1'b1;
                s_nxt.state = pcs_pkg::ST_DONE;
              end
            end
            pcs_pkg::OP_STEP:
            begin
              if (29'(step_abs) <= step_lim)
              begin
                s_nxt.move_steps = {{4{word[27]}}, word[27:0]};
                s_nxt.move_strobe = 1'b1;
                s_nxt.state = pcs_pkg::ST_MOVE;
              end
              else
              begin
                s_nxt.cmd_error = 1'b1;
                s_nxt.state = pcs_pkg::ST_DONE;
              end
            end
            pcs_pkg::OP_JUMP: s_nxt.pc = chan_entry[word[7:0]];
            pcs_pkg::OP_RESTORE: s_nxt.local_valid = 4'h0;
            default:
            begin
              s_nxt.cmd_error = 1'b1;
              s_nxt.state = pcs_pkg::ST_DONE;
            end
          endcase
        end
      end
      pcs_pkg::ST_WAIT:
      begin
        // Freezing the divider under hold keeps the remaining time exact.
        if (!hold_act)
        begin
          s_nxt.tick_cnt = tick ? 16'h0000 : s_r.tick_cnt + 16'h0001;
          if (tick)
          begin
            s_nxt.wait_ticks = s_r.wait_ticks - 17'h00001;
            if (s_r.wait_ticks == 17'h00001)
              s_nxt.state = pcs_pkg::ST_RUN;
          end
        end
      end
      pcs_pkg::ST_MOVE:
      begin
        if (!s_r.move_strobe && !i_motion_active)
          s_nxt.state = pcs_pkg::ST_RUN;
      end
      pcs_pkg::ST_DONE:
      begin
        if (!i_motion_active)
        begin
          s_nxt.busy = 1'b0;
          if (!s_r.keep)
            s_nxt.local_valid = 4'h0;
          s_nxt.state = pcs_pkg::ST_IDLE;
        end
      end
      default: s_nxt.state = pcs_pkg::ST_IDLE;
    endcase
    // DONE is left alone so an abort still closes out and drops busy.
    if (estop_act && !(s_r.state inside {pcs_pkg::ST_IDLE, pcs_pkg::ST_DONE}))
      s_nxt.state = pcs_pkg::ST_DONE;
    if (i_wr)
    begin
      case (i_addr)
        pcs_pkg::REG_CTRL:
        begin
          s_nxt.keep = i_wdata[pcs_pkg::CTRL_KEEP_BIT];
          s_nxt.hold_nc = i_wdata[pcs_pkg::CTRL_HOLD_NC_BIT];
          s_nxt.estop_nc = i_wdata[pcs_pkg::CTRL_ESTOP_NC_BIT];
        end
        pcs_pkg::REG_PASSWORD:
          s_nxt.unlocked = (i_wdata == pcs_pkg::PASSWORD_KEY);
        pcs_pkg::REG_AUTO_EXEC:
        begin
          if (s_r.unlocked)
          begin
            s_nxt.unlocked = 1'b0;
            if (i_wdata == 32'hffffffff || i_wdata <= 32'h000000ff)
              s_nxt.auto_exec = i_wdata[8:0];
          end
        end
        pcs_pkg::REG_DIVISIONS:
        begin
          if (s_r.unlocked)
          begin
            s_nxt.unlocked = 1'b0;
            if (i_wdata != 32'h00000000 &&
                i_wdata <= 32'(pcs_pkg::DIVISIONS_MAX))
              s_nxt.divisions = i_wdata[21:0];
          end
        end
        pcs_pkg::REG_PROG_ADDR: s_nxt.prog_addr = i_wdata[5:0];
        pcs_pkg::REG_PROG_DATA: s_nxt.prog_addr = s_r.prog_addr + 6'h01;
        default:
        begin
          if (i_addr[7:4] == pcs_pkg::REG_GLOBAL_BASE[7:4])
            s_nxt.global_p[i_addr[3:2]] = i_wdata[23:0];
        end
      endcase
    end
    if (i_rd)
    begin
      case (i_addr)
        pcs_pkg::REG_CTRL:
          s_nxt.rdata = {29'h0, s_r.estop_nc, s_r.hold_nc, s_r.keep};
        pcs_pkg::REG_STATUS:
          s_nxt.rdata = {s_r.chan, s_r.pc, 3'h0, s_r.state,
            s_r.local_valid, s_r.unlocked, s_r.cmd_error, s_r.init_done,
            estop_act, hold_act, s_r.busy};
        pcs_pkg::REG_AUTO_EXEC:
          s_nxt.rdata = {{23{s_r.auto_exec[8]}}, s_r.auto_exec};
        pcs_pkg::REG_DIVISIONS: s_nxt.rdata = {10'h0, s_r.divisions};
        pcs_pkg::REG_PROG_ADDR: s_nxt.rdata = {26'h0, s_r.prog_addr};
        pcs_pkg::REG_PROG_DATA: s_nxt.rdata = prog_mem[s_r.prog_addr];
        default:
        begin
          if (i_addr[7:4] == pcs_pkg::REG_GLOBAL_BASE[7:4])
            s_nxt.rdata = {8'h0, s_r.global_p[i_addr[3:2]]};
          else if (i_addr[7:4] == pcs_pkg::REG_EFFECT_BASE[7:4])
            s_nxt.rdata = {8'h0, eff_p[i_addr[3:2]]};
        end
      endcase
    end
    if (!i_rstn)
    begin
      s_nxt = '0;
      s_nxt.state = pcs_pkg::ST_IDLE;
      s_nxt.hold_nc = 1'b1;
      s_nxt.estop_nc = 1'b1;
      s_nxt.auto_exec = pcs_pkg::AUTO_EXEC_RST;
      s_nxt.divisions = pcs_pkg::DIVISIONS_RST;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk)
  begin
    s_r <= s_nxt;
  end
  // Program contents survive reset; software reloads them after power-up.
  always_ff @(posedge i_clk)
  begin
    if (i_wr && i_addr == pcs_pkg::REG_PROG_DATA)
      prog_mem[s_r.prog_addr] <= i_wdata;
    if (i_wr && i_addr == pcs_pkg::REG_CHAN_ENTRY)
      chan_entry[i_wdata[7:0]] <= i_wdata[13:8];
  end
  ////////////////////////////////////////////////////////////////////////////
  assign o_rdata = s_r.rdata;
  assign o_busy = s_r.busy;
  assign o_normal_state_output = ~(i_alarm | i_warning | estop_act);
  assign o_in_position_output = i_positioning_done & i_target_held &
    ~estop_act & (s_r.state != pcs_pkg::ST_MOVE);
  assign o_estop_active = estop_act;
  assign o_move_steps = s_r.move_steps;
  assign o_move_strobe = s_r.move_strobe;
endmodule

// ### sim/pcs_motion_model.sv
`timescale 1ns/100ps
module pcs_motion_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_move_strobe,
  input wire logic i_slow,
  output logic o_motion_active,
  output logic o_positioning_done,
  output logic o_target_held
);
  logic [5:0] cnt_r;
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      cnt_r <= 6'h00;
      o_motion_active <= 1'b0;
      o_positioning_done <= 1'b0;
      o_target_held <= 1'b0;
    end
    else if (i_move_strobe)
    begin
      // Motion shows in the cycle after the strobe, else the move ends early.
      o_motion_active <= 1'b1;
      o_positioning_done <= 1'b0;
      o_target_held <= 1'b0;
      cnt_r <= i_slow ? 6'h28 : 6'h03;
    end
    else if (cnt_r != 6'h00)
      cnt_r <= cnt_r - 6'h01;
    else if (o_motion_active)
    begin
      o_motion_active <= 1'b0;
      o_positioning_done <= 1'b1;
      o_target_held <= 1'b1;
    end
  end
endmodule

// ### sim/pcs_assertions.sv
`timescale 1ns/100ps
module pcs_checker #(
  parameter int PARAM_CYCLES = 4,
  parameter int INIT_CYCLES = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_program_start,
  input wire logic i_operation_hold_input,
  input wire logic i_emergency_stop_input,
  input wire logic i_alarm,
  input wire logic i_warning,
  input wire logic i_motion_active,
  input wire logic i_positioning_done,
  input wire logic i_target_held,
  input wire logic o_busy,
  input wire logic o_normal_state_output,
  input wire logic o_in_position_output,
  input wire logic o_estop_active,
  input wire logic o_move_strobe
);
  int cnt;
  logic ready;
  // Auto start may launch at init end, so launch checks wait past it.
  assign ready = cnt > INIT_CYCLES + 2;
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      cnt <= 0;
    else if (!ready)
      cnt <= cnt + 1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////////
  a_start_busy: assert property (
    ready && i_program_start && !$past(i_program_start) && !o_busy &&
    !o_estop_active |=> o_busy) else $error("busy late after start");
  a_no_launch: assert property (
    ready && !o_busy && !(i_program_start && !$past(i_program_start))
    |=> !o_busy) else $error("busy without start edge");
  a_normal_out: assert property (
    o_normal_state_output == !(i_alarm || i_warning || o_estop_active))
    else $error("normal output wrong");
  a_in_position: assert property (
    o_in_position_output |-> i_positioning_done && i_target_held &&
    !o_estop_active) else $error("in position output wrong");
  a_in_position_idle: assert property (
    !o_busy && !o_estop_active && i_positioning_done && i_target_held
    |-> o_in_position_output) else $error("in position open when idle");
  a_estop_decode: assert property (
    o_estop_active == !i_emergency_stop_input) else $error("estop decode");
  a_strobe_pulse: assert property (
    o_move_strobe |=> !o_move_strobe) else $error("strobe too long");
  a_strobe_busy: assert property (
    o_move_strobe |-> o_busy) else $error("strobe outside program");
  a_hold_freeze: assert property (
    $past(i_operation_hold_input) == 1'b0 && $past(o_busy)
    |-> !o_move_strobe) else $error("move while held");
  a_busy_release: assert property (
    $fell(o_busy) |-> !$past(i_motion_active))
    else $error("busy opened during motion");
  c_move: cover property (o_move_strobe);
  c_held: cover property (o_busy && !i_operation_hold_input);
  c_end: cover property ($fell(o_busy));
endmodule
bind pcs_sequencer pcs_checker #(.PARAM_CYCLES(PARAM_CYCLES),
  .INIT_CYCLES(INIT_CYCLES)) u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_program_start(i_program_start),
  .i_operation_hold_input(i_operation_hold_input),
  .i_emergency_stop_input(i_emergency_stop_input), .i_alarm(i_alarm),
  .i_warning(i_warning), .i_motion_active(i_motion_active),
  .i_positioning_done(i_positioning_done), .i_target_held(i_target_held),
  .o_busy(o_busy), .o_normal_state_output(o_normal_state_output),
  .o_in_position_output(o_in_position_output),
  .o_estop_active(o_estop_active), .o_move_strobe(o_move_strobe));

// ### sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] sel = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0, rd = 1'b0, start = 1'b0, hold = 1'b1, estop = 1'b1;
  logic alarm = 1'b0, warn = 1'b0, slow = 1'b0;
  logic [31:0] rdata, steps;
  logic busy, normal_state_output, inpos, estop_act, strobe, mact, pdone, held;
  int fail_count = 0, samples_checked = 0, n, stp;
  logic [31:0] prog [9] = '{32'h13000123, 32'h20000055, 32'h40000008,
    32'h0, 32'h60000000, 32'h0, 32'h40000191, 32'h30000002, 32'h0};
  logic [31:0] ent [4] = '{32'h0, 32'h401, 32'h602, 32'h703};
  always #5 clk = ~clk;
  pcs_sequencer #(.PARAM_CYCLES(4), .INIT_CYCLES(8)) DUT (.i_clk(clk),
    .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_program_start(start), .i_channel_select_inputs(sel),
    .i_operation_hold_input(hold), .i_emergency_stop_input(estop),
    .i_alarm(alarm), .i_warning(warn), .i_motion_active(mact),
    .i_positioning_done(pdone), .i_target_held(held), .o_busy(busy),
    .o_normal_state_output(normal_state_output), .o_in_position_output(inpos),
    .o_estop_active(estop_act), .o_move_steps(steps), .o_move_strobe(strobe));
  pcs_motion_model u_mot (.i_clk(clk), .i_rstn(rstn), .i_move_strobe(strobe),
    .i_slow(slow), .o_motion_active(mact), .o_positioning_done(pdone),
    .o_target_held(held));
  ////////////////////////////////////////////////////////////////////////////
  task close_out();
    if (fail_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task unlock();
    wrr(pcs_pkg::REG_PASSWORD, pcs_pkg::PASSWORD_KEY);
  endtask
  // Start stays high past the end, so a level restart would show as busy.
  task run(input logic [7:0] ch, input logic eb);
    @(posedge clk);
    sel <= ch;
    repeat (3) @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    #1 chk({31'h0, busy}, {31'h0, eb});
    n = 0;
    stp = 0;
    while (busy && n < 400)
    begin
      @(posedge clk);
      #1 n++;
      if (strobe && stp == 0)
        stp = n;
      if (n == 30 && !hold)
      begin
        chk({31'h0, busy}, 32'h1);
        chk(stp, 32'h0);
        hold <= 1'b1;
      end
    end
    repeat (4) @(posedge clk);
    #1 chk({31'h0, busy}, 32'h0);
    @(posedge clk);
    start <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (12) @(posedge clk);
    #1 chk({31'h0, busy}, 32'h0);
    rdc(pcs_pkg::REG_CTRL, 32'h6);
    rdc(pcs_pkg::REG_AUTO_EXEC, 32'hffffffff);
    rdc(pcs_pkg::REG_DIVISIONS, 32'h57e40);
    rdc(8'h40, 32'h0);
    wrr(pcs_pkg::REG_DIVISIONS, 32'h4);
    rdc(pcs_pkg::REG_DIVISIONS, 32'h57e40);
    unlock();
    wrr(pcs_pkg::REG_DIVISIONS, 32'h0);
    rdc(pcs_pkg::REG_DIVISIONS, 32'h57e40);
    unlock();
    wrr(pcs_pkg::REG_DIVISIONS, 32'h4);
    rdc(pcs_pkg::REG_DIVISIONS, 32'h4);
    unlock();
    wrr(pcs_pkg::REG_AUTO_EXEC, 32'h5);
    rdc(pcs_pkg::REG_AUTO_EXEC, 32'h5);
    wrr(pcs_pkg::REG_GLOBAL_BASE, 32'h7);
    wrr(pcs_pkg::REG_PROG_ADDR, 32'h0);
    foreach (prog[i])
      wrr(pcs_pkg::REG_PROG_DATA, prog[i]);
    foreach (ent[i])
      wrr(pcs_pkg::REG_CHAN_ENTRY, ent[i]);
    run(8'h00, 1'b1);
    chk({31'h0, stp >= 16 && stp <= 22}, 32'h1);
    chk(steps, 32'h8);
    chk({31'h0, inpos}, 32'h1);
    rdc(pcs_pkg::REG_EFFECT_BASE, 32'h7);
    wrr(pcs_pkg::REG_CTRL, 32'h7);
    run(8'h00, 1'b1);
    for (int i = 0; i < 4; i++)
      rdc(8'(pcs_pkg::REG_EFFECT_BASE + 4 * i), i == 3 ? 32'h123 : 32'h55);
    run(8'h01, 1'b1);
    rdc(pcs_pkg::REG_EFFECT_BASE, 32'h7);
    run(8'h02, 1'b1);
    chk(stp, 32'h0);
    run(8'h03, 1'b1);
    chk({31'h0, n >= 9 && n <= 14}, 32'h1);
    slow <= 1'b1;
    hold <= 1'b0;
    run(8'h00, 1'b1);
    chk(steps, 32'h8);
    slow <= 1'b0;
    estop <= 1'b0;
    @(posedge clk);
    #1 chk({31'h0, estop_act}, 32'h1);
    run(8'h00, 1'b0);
    estop <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      alarm <= k[0];
      warn <= k[1];
      @(posedge clk);
      #1 chk({31'h0, normal_state_output}, {31'h0, k == 0});
    end
    rdc(pcs_pkg::REG_EFFECT_BASE, 32'h55);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (12) @(posedge clk);
    rdc(pcs_pkg::REG_EFFECT_BASE, 32'h0);
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule
